// ==== rtl/mic_top.sv ====
// Purpose: interrupt controller of a small 8-bit core
// Assumes: all inputs synchronous to clock; core handshakes by strobes
// Notes: plain ports, no register bus
// Contract
// - four maskable vectors plus one non-maskable
// - requests latched while disabled, served later
// - reset pre-empts every service routine
// - nmi top priority, never nests itself
// - maskable never nest; vector 1 highest
// - any request wakes wait when global enable set; some wake stop
// - nmi falling edge sets request flip-flop
// - peripheral request needs flag, enable, global
// - port vectors need global enable; wake stop
// - vector 1 edge or level selectable
// - vector 2 edge only, polarity selectable
// - edge latch holds one request, cleared on entry
// - level mode stores nothing, sampled at boundary
// - switching to rising edge latches spurious request
// - vector 2 pins combined; held level masks others
// - reconfig of low pin latches spurious request
// - entry switches flags, pushes pc, loads vector
// - return restores interrupted routine
// - early option clear keeps normal flags
// - response takes 6 to 11 cpu cycles
// - option bit 6 selects low-level on vector 1
// - option bit 5 selects rising edge on vector 2
// - option bit 4 global enable, reset zero
// - fixed vector addresses per source
`timescale 1ns/1ns
module mic_top
   import mic_pkg::*;
#(
   parameter int V2_PINS = 8
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic nmi_n,
   input wire logic porta_irq_n,
   input wire logic [V2_PINS-1:0] portb_pin,
   input wire logic [V2_PINS-1:0] portb_irq_en,
   input wire logic opt_wr,
   input wire logic [7:0] opt_wdata,
   input wire logic opt_wr_early,
   input wire logic timer_flag,
   input wire logic timer_en,
   input wire logic timer_stop_wake,
   input wire logic adc_flag,
   input wire logic adc_en,
   input wire logic adc_stop_wake,
   input wire logic instr_done,
   input wire logic entry_ack,
   input wire logic return_from_irq,
   input wire logic in_wait,
   input wire logic in_stop,
   output logic irq_take,
   output logic [11:0] vec_addr_ff,
   output logic [2:0] vec_src_ff,
   output logic push_pc,
   output logic use_irq_flags_ff,
   output logic use_nmi_flags_ff,
   output logic keep_normal_flags_ff,
   output logic maskable_inhibit,
   output logic wake,
   output logic global_irq_enable,
   output logic [7:0] resp_cnt_ff
);
   mic_state_t state_ff;
   mic_state_t nxt_state;
   mic_state_t ret_state_ff;
   mic_opt_t opt_ff;
   logic nmi_prev_ff;
   logic nmi_req_ff;
   logic v1_req;
   logic v1_edge_req;
   logic v2_req;
   logic v2_any;
   logic v2_prev_en_any_ff;
   logic v2_spur;
   logic v1_level_hit;
   logic [3:0] pend;
   logic [2:0] pick;
   logic nmi_edge;
   logic take_nmi;
   logic take_mask;
   logic clr_v1;
   logic clr_v2;
   logic [V2_PINS-1:0] en_prev_ff;
   logic [V2_PINS-1:0] reconf;

   assign global_irq_enable = opt_ff.global_irq_enable;

   // option register, write only, reset to zero
   always_ff @(posedge clock)
   begin
      if (reset)
         opt_ff <= mic_opt_t'(3'h0);
      else if (opt_wr)
      begin
         opt_ff.vec1_level_edge_select <= opt_wdata[OPT_LES_BIT];
         opt_ff.vec2_edge_polarity <= opt_wdata[OPT_ESB_BIT];
         opt_ff.global_irq_enable <= opt_wdata[OPT_GEN_BIT];
      end
   end

   // nmi falling edge flip-flop, independent of enable
   assign nmi_edge = nmi_prev_ff & ~nmi_n;
   always_ff @(posedge clock)
   begin
      if (reset)
         nmi_prev_ff <= 1'b1;
      else
         nmi_prev_ff <= nmi_n;
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         nmi_req_ff <= 1'b0;
      else if (nmi_edge)
         nmi_req_ff <= 1'b1;
      else if (take_nmi && entry_ack)
         nmi_req_ff <= 1'b0;
   end

   // vector 1: falling edge latch or sampled low level
   assign clr_v1 = take_mask && entry_ack && pick == SRC_V1;
   mic_edge_latch u_v1 (
      .clock(clock),
      .reset(reset),
      .line(porta_irq_n),
      .rising(1'b0),
      .force_set(1'b0),
      .clr(clr_v1 | opt_ff.vec1_level_edge_select),
      .req_ff(v1_edge_req)
   );
   assign v1_level_hit = ~porta_irq_n & instr_done;
   assign v1_req = opt_ff.vec1_level_edge_select ? v1_level_hit
                   : v1_edge_req;

   // vector 2: enabled pins combined into one line
   assign v2_any = opt_ff.vec2_edge_polarity
                   ? |(portb_pin & portb_irq_en)
                   : ~|(~portb_pin & portb_irq_en);
   always_ff @(posedge clock)
   begin
      if (reset)
         en_prev_ff <= '0;
      else
         en_prev_ff <= portb_irq_en;
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         v2_prev_en_any_ff <= 1'b0;
      else
         v2_prev_en_any_ff <= |portb_irq_en;
   end
   assign reconf = (en_prev_ff ^ portb_irq_en) & ~portb_pin;
   assign v2_spur = (|reconf)
      | (opt_wr && opt_wdata[OPT_ESB_BIT] && !opt_ff.vec2_edge_polarity
         && v2_prev_en_any_ff);
   assign clr_v2 = take_mask && entry_ack && pick == SRC_V2;
   mic_edge_latch u_v2 (
      .clock(clock),
      .reset(reset),
      .line(v2_any),
      .rising(opt_ff.vec2_edge_polarity),
      .force_set(v2_spur),
      .clr(clr_v2),
      .req_ff(v2_req)
   );

   // pending maskable set, requests held regardless of global enable
   assign pend = {adc_flag & adc_en, timer_flag & timer_en,
                  v2_req, v1_req};
   mic_prio u_prio (
      .pend(pend),
      .src(pick)
   );

   // grants: nmi over maskable, nmi nests only into a maskable routine
   assign take_nmi = nmi_req_ff && state_ff != MIC_NMI_ISR
                     && state_ff != MIC_ENTRY && instr_done;
   assign take_mask = !take_nmi && state_ff == MIC_NORMAL && instr_done
                      && opt_ff.global_irq_enable
                      && pick != SRC_NONE;
   assign irq_take = take_nmi | take_mask;
   assign maskable_inhibit = state_ff != MIC_NORMAL;
   assign push_pc = irq_take & entry_ack;

   // wake from wait or stop
   always_comb
   begin
      wake = 1'b0;
      if (in_wait)
         wake = opt_ff.global_irq_enable & ((|pend) | nmi_req_ff);
      else if (in_stop)
         wake = opt_ff.global_irq_enable & (v1_req | v2_req | nmi_req_ff
            | (pend[2] & timer_stop_wake)
            | (pend[3] & adc_stop_wake));
   end

   // vector address and source for the core
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         vec_addr_ff <= 12'h000;
         vec_src_ff <= SRC_NONE;
      end
      else if (take_nmi && entry_ack)
      begin
         vec_addr_ff <= VEC_ADDR_NMI;
         vec_src_ff <= SRC_NMI;
      end
      else if (take_mask && entry_ack)
      begin
         vec_src_ff <= pick;
         case (pick)
            SRC_V1: vec_addr_ff <= VEC_ADDR_V1;
            SRC_V2: vec_addr_ff <= VEC_ADDR_V2;
            SRC_V3: vec_addr_ff <= VEC_ADDR_V3;
            SRC_V4: vec_addr_ff <= VEC_ADDR_V4;
            default: vec_addr_ff <= 12'h000;
         endcase
      end
   end

   // state machine: accept goes straight to service, return unwinds one level
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         MIC_NORMAL:
            if (irq_take && entry_ack)
               nxt_state = take_nmi ? MIC_NMI_ISR : MIC_MASK_ISR;
         MIC_MASK_ISR:
            if (take_nmi && entry_ack)
               nxt_state = MIC_NMI_ISR;
            else if (return_from_irq)
               nxt_state = MIC_NORMAL;
         MIC_NMI_ISR:
            if (return_from_irq)
               nxt_state = ret_state_ff;
         MIC_ENTRY:
            nxt_state = MIC_NORMAL;
         default:
            nxt_state = MIC_NORMAL;
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         state_ff <= MIC_NMI_ISR;
      else
         state_ff <= nxt_state;
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         ret_state_ff <= MIC_NORMAL;
      else if (take_nmi && entry_ack)
         ret_state_ff <= (state_ff == MIC_MASK_ISR) ? MIC_MASK_ISR
                         : MIC_NORMAL;
   end

   // flag set selection
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         use_irq_flags_ff <= 1'b0;
         use_nmi_flags_ff <= 1'b1;
      end
      else
      begin
         use_nmi_flags_ff <= nxt_state == MIC_NMI_ISR;
         use_irq_flags_ff <= nxt_state == MIC_MASK_ISR
                             && !(take_mask && entry_ack
                                  && opt_wr_early);
      end
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         keep_normal_flags_ff <= 1'b0;
      else if (take_mask && entry_ack)
         keep_normal_flags_ff <= opt_wr_early;
      else if (nxt_state == MIC_NORMAL)
         keep_normal_flags_ff <= 1'b0;
   end

   // response timer in core clocks, from grant to vector fetch
   always_ff @(posedge clock)
   begin
      if (reset)
         resp_cnt_ff <= 8'h00;
      else if (irq_take && entry_ack)
         resp_cnt_ff <= 8'h01;
      else if (resp_cnt_ff != 8'h00
               && resp_cnt_ff < 8'(RESP_MAX_CLKS))
         resp_cnt_ff <= resp_cnt_ff + 8'h01;
      else
         resp_cnt_ff <= 8'h00;
   end
endmodule

// ==== pkg/mic_pkg.sv ====
// Purpose: shared constants and types of the interrupt controller
// Assumes: one 100 MHz core clock
// Notes: vector addresses are 12-bit program addresses
package mic_pkg;
   localparam int NUM_VEC = 5;
   localparam logic [11:0] VEC_ADDR_NMI = 12'hFFC;
   localparam logic [11:0] VEC_ADDR_V1 = 12'hFF6;
   localparam logic [11:0] VEC_ADDR_V2 = 12'hFF4;
   localparam logic [11:0] VEC_ADDR_V3 = 12'hFF2;
   localparam logic [11:0] VEC_ADDR_V4 = 12'hFF0;
   localparam int OPT_LES_BIT = 6;
   localparam int OPT_ESB_BIT = 5;
   localparam int OPT_GEN_BIT = 4;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam int CPU_CYC_CLKS = 13;
   localparam int RESP_MIN_CPU = 6;
   localparam int RESP_MAX_CPU = 11;
   localparam int RESP_MIN_CLKS = RESP_MIN_CPU * CPU_CYC_CLKS;
   localparam int RESP_MAX_CLKS = RESP_MAX_CPU * CPU_CYC_CLKS;
   localparam int LDI_CLR_CYCLES = 4;
   localparam int LDI_CLR_LATE = 3;
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_V1 = 3'h1;
   localparam logic [2:0] SRC_V2 = 3'h2;
   localparam logic [2:0] SRC_V3 = 3'h3;
   localparam logic [2:0] SRC_V4 = 3'h4;
   localparam logic [2:0] SRC_NMI = 3'h5;
   typedef enum logic [3:0] {
      MIC_NORMAL = 4'h1,
      MIC_ENTRY = 4'h2,
      MIC_MASK_ISR = 4'h4,
      MIC_NMI_ISR = 4'h8
   } mic_state_t;
   typedef struct packed {
      logic vec1_level_edge_select;
      logic vec2_edge_polarity;
      logic global_irq_enable;
   } mic_opt_t;
   typedef struct packed {
      logic valid;
      logic [2:0] src;
      logic [11:0] addr;
      logic keep_normal_flags;
   } mic_entry_t;
endpackage

// ==== rtl/mic_edge_latch.sv ====
// Purpose: edge request latch with collapse of repeated edges
// Assumes: input sampled on the core clock
// Notes: set wins over clear
`timescale 1ns/1ns
module mic_edge_latch
   import mic_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic line,
   input wire logic rising,
   input wire logic force_set,
   input wire logic clr,
   output logic req_ff
);
   logic prev_ff;
   logic hit;
   always_ff @(posedge clock)
   begin
      if (reset)
         prev_ff <= 1'b1;
      else
         prev_ff <= line;
   end
   assign hit = (rising ? (line & ~prev_ff) : (~line & prev_ff)) | force_set;
   always_ff @(posedge clock)
   begin
      if (reset)
         req_ff <= 1'b0;
      else if (hit)
         req_ff <= 1'b1;
      else if (clr)
         req_ff <= 1'b0;
   end
endmodule

// ==== rtl/mic_prio.sv ====
// Purpose: fixed priority pick among pending maskable vectors
// Assumes: bit 0 is vector #1
// Notes: combinational
`timescale 1ns/1ns
module mic_prio
   import mic_pkg::*;
(
   input wire logic [3:0] pend,
   output logic [2:0] src
);
   always_comb
   begin
      if (pend[0])
         src = SRC_V1;
      else if (pend[1])
         src = SRC_V2;
      else if (pend[2])
         src = SRC_V3;
      else if (pend[3])
         src = SRC_V4;
      else
         src = SRC_NONE;
   end
endmodule

// ==== tb/mic_monitor.sv ====
// Purpose: port checks of the interrupt controller
// Assumes: one clock, sync reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module mic_monitor
   import mic_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic opt_wr,
   input wire logic [7:0] opt_wdata,
   input wire logic opt_wr_early,
   input wire logic instr_done,
   input wire logic entry_ack,
   input wire logic return_from_irq,
   input wire logic irq_take,
   input wire logic [11:0] vec_addr_ff,
   input wire logic [2:0] vec_src_ff,
   input wire logic push_pc,
   input wire logic use_irq_flags_ff,
   input wire logic use_nmi_flags_ff,
   input wire logic keep_normal_flags_ff,
   input wire logic maskable_inhibit,
   input wire logic wake,
   input wire logic global_irq_enable
);
   logic gen_ff;
   wire logic acc = irq_take && entry_ack;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   always_ff @(posedge clock)
   begin
      gen_ff <= opt_wdata[OPT_GEN_BIT];
   end
   a_push_on_accept: assert property (push_pc == acc)
      else $error("push differs from accept");
   a_grant_at_boundary: assert property (irq_take |-> instr_done)
      else $error("grant off boundary");
   a_vector_address: assert property (acc |=> vec_src_ff inside {[1:5]} &&
      vec_addr_ff == (vec_src_ff == SRC_NMI ? VEC_ADDR_NMI :
      12'hFF8 - {8'h00, vec_src_ff, 1'b0})) else $error("bad vector");
   a_entry_inhibits: assert property (acc |=> maskable_inhibit &&
      (use_irq_flags_ff || use_nmi_flags_ff || keep_normal_flags_ff))
      else $error("no inhibit");
   a_nmi_flag_set: assert property (acc ##1 vec_src_ff == SRC_NMI
      |-> use_nmi_flags_ff) else $error("nmi flags not used");
   a_no_mask_nest: assert property (acc && maskable_inhibit
      |=> vec_src_ff == SRC_NMI) else $error("maskable nested");
   a_nmi_no_nest: assert property (use_nmi_flags_ff && !return_from_irq
      |-> !irq_take) else $error("grant inside nmi");
   a_gen_gates_mask: assert property (acc && !global_irq_enable
      |=> vec_src_ff == SRC_NMI) else $error("maskable while disabled");
   a_option_write: assert property (opt_wr
      |=> global_irq_enable == gen_ff) else $error("enable not written");
   a_wake_needs_gen: assert property (wake |-> global_irq_enable)
      else $error("wake while disabled");
   a_early_keeps: assert property (acc && opt_wr_early && !maskable_inhibit
      |=> vec_src_ff == SRC_NMI || keep_normal_flags_ff)
      else $error("normal flags not kept");
   a_return_ends: assert property (return_from_irq && !acc &&
      use_irq_flags_ff && !use_nmi_flags_ff |=> !maskable_inhibit)
      else $error("routine not ended");
   c_nmi_entry: cover property (acc ##1 vec_src_ff == SRC_NMI);
   c_early_entry: cover property (acc && opt_wr_early);
   c_wake: cover property (wake);
endmodule

// ==== tb/mic_core_model.sv ====
// Purpose: core side model giving boundaries and accepts
// Assumes: boundary every 4 or every 8 cycles
// Notes: halt models a sleeping core
`timescale 1ns/1ns
module mic_core_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic halt,
   input wire logic slow,
   input wire logic irq_take,
   output logic instr_done,
   output logic entry_ack
);
   logic [2:0] cnt_ff;
   always_ff @(posedge clock)
   begin
      if (reset || halt)
         cnt_ff <= 3'h0;
      else
         cnt_ff <= cnt_ff + 3'h1;
   end
   assign instr_done = !halt && (slow ? cnt_ff == 3'h7 : cnt_ff[1:0] == 2'h3);
   assign entry_ack = irq_take && instr_done;
endmodule

// ==== tb/mcu_interrupt_controller_test.sv ====
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model gives boundaries and accepts
// Notes: random request mixes from a fixed seed
`timescale 1ns/1ns
module mcu_interrupt_controller_test
   import mic_pkg::*;
   ;
   logic clock = 1'b0, reset = 1'b1, nmi_n = 1'b1, porta_irq_n = 1'b1;
   logic opt_wr = 1'b0, opt_wr_early = 1'b0, return_from_irq = 1'b0;
   logic timer_flag = 1'b0, timer_en = 1'b1, timer_stop_wake = 1'b1;
   logic adc_flag = 1'b0, adc_en = 1'b1, adc_stop_wake = 1'b0;
   logic in_wait = 1'b0, in_stop = 1'b0, slow = 1'b0, halt = 1'b0;
   logic [7:0] portb_pin = 8'hFF, portb_irq_en = 8'hFF, opt_wdata = 8'h00;
   logic irq_take, push_pc, use_irq_flags_ff, use_nmi_flags_ff, wake;
   logic keep_normal_flags_ff, maskable_inhibit, global_irq_enable;
   logic instr_done, entry_ack;
   logic [11:0] vec_addr_ff, pushes = 12'h000;
   logic [2:0] vec_src_ff;
   logic [7:0] resp_cnt_ff;
   logic [31:0] seed, m;
   int fails = 0, samples_checked = 0, cycles = 0;
   always #5 clock = ~clock;
   mic_top #(.V2_PINS(8)) DUT (.clock(clock), .reset(reset), .nmi_n(nmi_n),
      .porta_irq_n(porta_irq_n), .portb_pin(portb_pin),
      .portb_irq_en(portb_irq_en), .opt_wr(opt_wr), .opt_wdata(opt_wdata),
      .opt_wr_early(opt_wr_early), .timer_flag(timer_flag),
      .timer_en(timer_en), .timer_stop_wake(timer_stop_wake),
      .adc_flag(adc_flag), .adc_en(adc_en), .adc_stop_wake(adc_stop_wake),
      .instr_done(instr_done), .entry_ack(entry_ack),
      .return_from_irq(return_from_irq), .in_wait(in_wait),
      .in_stop(in_stop), .irq_take(irq_take), .vec_addr_ff(vec_addr_ff),
      .vec_src_ff(vec_src_ff), .push_pc(push_pc),
      .use_irq_flags_ff(use_irq_flags_ff),
      .use_nmi_flags_ff(use_nmi_flags_ff),
      .keep_normal_flags_ff(keep_normal_flags_ff),
      .maskable_inhibit(maskable_inhibit), .wake(wake),
      .global_irq_enable(global_irq_enable), .resp_cnt_ff(resp_cnt_ff));
   mic_core_model core (.clock(clock), .reset(reset), .halt(halt),
      .slow(slow), .irq_take(irq_take), .instr_done(instr_done),
      .entry_ack(entry_ack));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] addr_of(input logic [2:0] s);
      case (s)
         SRC_V1: return 12'hFF6;
         SRC_V2: return 12'hFF4;
         SRC_V3: return 12'hFF2;
         SRC_V4: return 12'hFF0;
         default: return 12'hFFC;
      endcase
   endfunction
   task automatic wr_opt(input logic [7:0] v);
      @(posedge clock);
      opt_wr <= 1'b1;
      opt_wdata <= v;
      @(posedge clock);
      opt_wr <= 1'b0;
   endtask
   task automatic pulse(input int p);
      @(posedge clock);
      if (p < 0)
         porta_irq_n <= 1'b0;
      else
         portb_pin[p] <= 1'b0;
      @(posedge clock);
      porta_irq_n <= 1'b1;
      portb_pin <= 8'hFF;
   endtask
   task automatic quiet(input int n);
      logic [11:0] p;
      @(negedge clock);
      p = pushes;
      repeat (n) @(negedge clock);
      chk(pushes, p);
   endtask
   task automatic serve(input logic [2:0] s, input logic kn);
      logic [11:0] p;
      p = pushes;
      repeat (60)
      begin
         @(negedge clock);
         if (push_pc === 1'b1)
            break;
      end
      @(negedge clock);
      chk(pushes, p + 12'h001);
      chk({4'h0, resp_cnt_ff}, 12'h001);
      chk(vec_src_ff, s);
      chk(vec_addr_ff, addr_of(s));
      chk(keep_normal_flags_ff, kn);
   endtask
   task automatic fin(input logic [2:0] s);
      @(posedge clock);
      porta_irq_n <= 1'b1;
      opt_wr_early <= 1'b0;
      if (s == SRC_V3)
         timer_flag <= 1'b0;
      if (s == SRC_V4)
         adc_flag <= 1'b0;
      @(posedge clock);
      return_from_irq <= 1'b1;
      @(posedge clock);
      return_from_irq <= 1'b0;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (push_pc === 1'b1)
         pushes <= pushes + 12'h001;
      if (cycles == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   initial
   begin
      seed = 32'hfd206eb2;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      chk(global_irq_enable, 1'b0);
      chk(use_nmi_flags_ff, 1'b1);
      fin(SRC_NONE);
      $display("test 1 done");
      pulse(-1);
      pulse(-1);
      pulse(3);
      timer_flag <= 1'b1;
      quiet(30);
      opt_wr_early <= 1'b1;
      wr_opt(8'h10);
      serve(SRC_V1, 1'b1);
      fin(SRC_V1);
      serve(SRC_V2, 1'b0);
      fin(SRC_V2);
      serve(SRC_V3, 1'b0);
      fin(SRC_V3);
      quiet(30);
      $display("test 2 done");
      repeat (6)
      begin
         m = $random(seed);
         wr_opt(8'h00);
         slow <= m[4];
         if (m[0])
            pulse(-1);
         if (m[1])
            pulse(int'(m[7:5]));
         timer_flag <= m[2];
         adc_flag <= m[3];
         wr_opt(8'h10);
         for (int s = 1; s < 5; s++)
            if (m[s-1])
            begin
               serve(3'(s), 1'b0);
               fin(3'(s));
            end
      end
      $display("test 3 done");
      timer_flag <= 1'b1;
      serve(SRC_V3, 1'b0);
      nmi_n <= 1'b0;
      serve(SRC_NMI, 1'b0);
      nmi_n <= 1'b1;
      fin(SRC_NMI);
      @(negedge clock);
      chk(maskable_inhibit, 1'b1);
      fin(SRC_V3);
      $display("test 4 done");
      wr_opt(8'h50);
      porta_irq_n <= 1'b0;
      serve(SRC_V1, 1'b0);
      fin(SRC_V1);
      quiet(30);
      $display("test 5 done");
      wr_opt(8'h10);
      wr_opt(8'h30);
      serve(SRC_V2, 1'b0);
      fin(SRC_V2);
      portb_irq_en <= 8'h20;
      pulse(5);
      serve(SRC_V2, 1'b0);
      fin(SRC_V2);
      portb_irq_en <= 8'hFF;
      $display("test 6 done");
      halt <= 1'b1;
      in_wait <= 1'b1;
      adc_flag <= 1'b1;
      wr_opt(8'h00);
      @(negedge clock);
      chk(wake, 1'b0);
      wr_opt(8'h10);
      @(negedge clock);
      chk(wake, 1'b1);
      in_wait <= 1'b0;
      in_stop <= 1'b1;
      @(negedge clock);
      chk(wake, 1'b0);
      adc_stop_wake <= 1'b1;
      @(negedge clock);
      chk(wake, 1'b1);
      in_stop <= 1'b0;
      halt <= 1'b0;
      serve(SRC_V4, 1'b0);
      fin(SRC_V4);
      $display("test 7 done");
      tally_and_finish();
   end
endmodule
bind mic_top mic_monitor mon (.clock(clock), .reset(reset), .opt_wr(opt_wr),
   .opt_wdata(opt_wdata), .opt_wr_early(opt_wr_early),
   .instr_done(instr_done), .entry_ack(entry_ack),
   .return_from_irq(return_from_irq), .irq_take(irq_take),
   .vec_addr_ff(vec_addr_ff), .vec_src_ff(vec_src_ff), .push_pc(push_pc),
   .use_irq_flags_ff(use_irq_flags_ff), .use_nmi_flags_ff(use_nmi_flags_ff),
   .keep_normal_flags_ff(keep_normal_flags_ff),
   .maskable_inhibit(maskable_inhibit), .wake(wake),
   .global_irq_enable(global_irq_enable));
